// ===== addr_map_pkg.sv
package addr_map_pkg;

	// strap decode: the low strap nibble selects the host bus type
	localparam int          STRAP_W        = 8;
	localparam int          BUS_SEL_LSB    = 0;
	localparam int          BUS_SEL_W      = 4;
	localparam logic [7:0]  STRAP_RST      = 8'h00;

	// internal byte address covers pins 18 down to 0
	localparam int          ADDR_W         = 19;
	localparam int          LOW_LSB        = 1;
	localparam int          LOW_W          = 12;
	localparam int          MID_LSB        = 13;
	localparam int          MID_W          = 4;
	localparam int          BIT17_POS      = 17;
	localparam int          BIT18_POS      = 18;
	localparam logic [18:0] ADDR_RST       = 19'h00000;

	// big-endian bus numbers bits from zero at the msb of a 32-bit word
	localparam int          BE_LSB_NUM     = 31;

	// level of an unused input that the board ties off
	localparam logic        TIE_LEVEL      = 1'b0;
	localparam logic [3:0]  MID_TIE_HIGH   = 4'hf;
	localparam logic        STROBE_IDLE    = 1'b1;

	typedef enum logic [3:0] {
		BUS_GENERIC    = 4'h0,
		BUS_PERIPH_A   = 4'h1,
		BUS_PERIPH_B   = 4'h2,
		BUS_WORD16     = 4'h3,
		BUS_BYTE32     = 4'h4,
		BUS_ISA        = 4'h5,
		BUS_PCCARD     = 4'h6,
		BUS_CARD_A     = 4'h7,
		BUS_CARD_B     = 4'h8,
		BUS_BIG_ENDIAN = 4'h9
	} bus_type_t;

	// unknown codes fall back to the generic bus
	function automatic bus_type_t decode_bus(input logic [7:0] straps);
		logic [3:0] sel;
		sel = straps[BUS_SEL_LSB +: BUS_SEL_W];
		if (sel > 4'h9) begin
			decode_bus = BUS_GENERIC;
		end else begin
			decode_bus = bus_type_t'(sel);
		end
	endfunction

	function automatic logic strap_illegal(input logic [7:0] straps);
		strap_illegal = (straps[BUS_SEL_LSB +: BUS_SEL_W] > 4'h9);
	endfunction

	function automatic logic is_card(input bus_type_t bt);
		is_card = (bt == BUS_CARD_A) || (bt == BUS_CARD_B);
	endfunction

	// modes whose lowest pin is tied off and carries nothing
	function automatic logic lowest_tied(input bus_type_t bt);
		lowest_tied = (bt == BUS_GENERIC) || (bt == BUS_PERIPH_A) ||
			(bt == BUS_PERIPH_B) || (bt == BUS_PCCARD);
	endfunction

	// byte weight of a big-endian host address bit number
	function automatic int be_weight(input int be_num);
		be_weight = BE_LSB_NUM - be_num;
	endfunction

endpackage

// ===== host_addr_if.sv
`timescale 1ns/1ns
interface host_addr_if;
	logic        lowest_addr_input;
	logic [11:0] low_addr_inputs;
	logic [3:0]  mid_addr_inputs;
	logic        addr_input_bit17;
	logic        addr_input_bit18;
	logic [7:0]  power_on_strap_pins;

	modport device (
		input lowest_addr_input,
		input low_addr_inputs,
		input mid_addr_inputs,
		input addr_input_bit17,
		input addr_input_bit18,
		input power_on_strap_pins
	);

	modport host (
		output lowest_addr_input,
		output low_addr_inputs,
		output mid_addr_inputs,
		output addr_input_bit17,
		output addr_input_bit18,
		output power_on_strap_pins
	);
endinterface

// ===== host_address_driver.sv
`timescale 1ns/1ns
module host_address_driver
	import addr_map_pkg::*;
#(
	parameter int PIN_ADDR_W = ADDR_W
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	host_addr_if.host         pins,
	input  wire logic [7:0]   strap_cfg,
	input  wire logic [18:0]  req_addr,
	input  wire logic         lower_byte_strobe_n,
	input  wire logic         card_io_write_n,
	input  wire logic         card_io_read_n,
	output bus_type_t         host_bus_type
);

	generate
		if (PIN_ADDR_W != ADDR_W) begin : g_bad_width
			$error("pin address width must be 19");
		end
	endgenerate

	logic [7:0]  strap_r;
	logic        lowest_r;
	logic [11:0] low_r;
	logic [3:0]  mid_r;
	logic        b17_r;
	logic        b18_r;
	bus_type_t   bt;

	assign bt = decode_bus(strap_r);
	assign host_bus_type = bt;

	// straps are registered from strap_cfg every cycle so the device can catch them after reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_r <= STRAP_RST;
		end else begin
			strap_r <= strap_cfg;
		end
	end

	// drive each pin with what the strapped bus puts on it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lowest_r <= TIE_LEVEL;
			low_r    <= '0;
			mid_r    <= '0;
			b17_r    <= STROBE_IDLE;
			b18_r    <= STROBE_IDLE;
		end else begin
			low_r <= req_addr[LOW_LSB +: LOW_W];
			if (lowest_tied(bt)) begin
				// either tie level is legal; two modes use the other one
				// so a device that wrongly reads the pin is caught
				lowest_r <= (bt == BUS_PERIPH_B || bt == BUS_PCCARD) ?
					~TIE_LEVEL : TIE_LEVEL;
			end else if (bt == BUS_WORD16) begin
				lowest_r <= lower_byte_strobe_n;
			end else begin
				lowest_r <= req_addr[0];
			end
			if (is_card(bt)) begin
				mid_r <= MID_TIE_HIGH;
				b17_r <= card_io_write_n;
				b18_r <= card_io_read_n;
			end else begin
				mid_r <= req_addr[MID_LSB +: MID_W];
				b17_r <= req_addr[BIT17_POS];
				b18_r <= req_addr[BIT18_POS];
			end
		end
	end

	assign pins.power_on_strap_pins = strap_r;
	assign pins.lowest_addr_input   = lowest_r;
	assign pins.low_addr_inputs     = low_r;
	assign pins.mid_addr_inputs     = mid_r;
	assign pins.addr_input_bit17    = b17_r;
	assign pins.addr_input_bit18    = b18_r;

endmodule

// ===== host_address_pin_mapper.sv
`timescale 1ns/1ns
// Operation
// - straps at power-on choose the bus type
// - host ties lowest pin off in some modes
// - word16 mode: lowest pin is lower byte strobe
// - byte32, isa, card modes: lowest pin is bit0
// - big-endian: lowest pin is host bit 31
// - big-endian: pins 12..1 are host bits 19..30
// - other modes: pins 12..1 are bits 12..1
// - card modes: host ties pins 16..13 high
// - big-endian: pins 16..13 are host bits 15..18
// - other modes: pins 16..13 are bits 16..13
// - card modes: pin 17 is io write strobe
// - non-card modes: pin 17 is host bit 14 or bit 17
// - card modes: pin 18 is io read strobe
// - big-endian: pin 18 is host bit 13
// - other non-card modes: pin 18 is bit 18
module host_address_pin_mapper
	import addr_map_pkg::*;
#(
	parameter int PIN_ADDR_W = ADDR_W
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	host_addr_if.device       pins,
	output bus_type_t         bus_type,
	output logic              map_ready,
	output logic              strap_bad,
	output logic [3:0]        spare_straps,
	output logic [18:0]       sys_addr,
	output logic              lower_byte_strobe_n,
	output logic              card_io_write_n,
	output logic              card_io_read_n
);

	generate
		if (PIN_ADDR_W != ADDR_W) begin : g_bad_width
			$error("pin address width must be 19");
		end
		// the pin fields must tile the address with no gap or overlap
		if (LOW_LSB + LOW_W != MID_LSB) begin : g_bad_low
			$error("low pins must end below the mid pins");
		end
		if (MID_LSB + MID_W != BIT17_POS) begin : g_bad_mid
			$error("mid pins must end below pin 17");
		end
		if (BIT18_POS != BIT17_POS + 1) begin : g_bad_top
			$error("pin 18 must sit just above pin 17");
		end
		if (BIT18_POS + 1 != ADDR_W) begin : g_bad_end
			$error("pin 18 must be the top address bit");
		end
		// the big-endian map relies on host bit 30 landing on pin 1
		if (BE_LSB_NUM - 30 != LOW_LSB) begin : g_bad_be
			$error("big-endian numbering does not match the pins");
		end
		if ($bits(bus_type_t) != BUS_SEL_W) begin : g_bad_sel
			$error("bus type code must match the strap select width");
		end
	endgenerate

	// strap capture
	logic        taken_r;
	bus_type_t   bus_type_r;
	logic        strap_bad_r;
	logic [3:0]  spare_r;

	// mapped address and strobes with their next values
	logic [18:0] addr_r;
	logic [18:0] addr_nxt;
	logic        lds_r;
	logic        lds_nxt;
	logic        iowr_r;
	logic        iowr_nxt;
	logic        iord_r;
	logic        iord_nxt;

	// place each big-endian pin by its host bit number
	function automatic logic [18:0] map_big_endian(
		input logic        ab0,
		input logic [11:0] low,
		input logic [3:0]  mid,
		input logic        b17,
		input logic        b18
	);
		logic [18:0] a;
		int          w;
		a = '0;
		w = be_weight(31);
		a[w] = ab0;
		// host bits 30 down to 19 sit on pins 1 up to 12
		for (int n = 19; n <= 30; n++) begin
			w = be_weight(n);
			a[w] = low[w - LOW_LSB];
		end
		// host bits 18 down to 15 sit on pins 13 up to 16
		for (int n = 15; n <= 18; n++) begin
			w = be_weight(n);
			a[w] = mid[w - MID_LSB];
		end
		w = be_weight(14);
		a[w] = b17;
		w = be_weight(13);
		a[w] = b18;
		map_big_endian = a;
	endfunction

	// the strap pins are caught once, on the first edge after release;
	// catching them later would let a moving pin retarget the bus
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			taken_r <= 1'b0;
		end else begin
			taken_r <= 1'b1;
		end
	end

	// captured bus type and strap flags, frozen until the next reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_type_r  <= BUS_GENERIC;
			strap_bad_r <= 1'b0;
			spare_r     <= 4'h0;
		end else if (!taken_r) begin
			bus_type_r  <= decode_bus(pins.power_on_strap_pins);
			strap_bad_r <= strap_illegal(pins.power_on_strap_pins);
			spare_r     <= pins.power_on_strap_pins[7:4];
		end
	end

	// pin interpretation per strapped bus type
	always_comb begin
		addr_nxt = ADDR_RST;
		lds_nxt  = STROBE_IDLE;
		iowr_nxt = STROBE_IDLE;
		iord_nxt = STROBE_IDLE;
		unique case (bus_type_r)
			BUS_BIG_ENDIAN: begin
				addr_nxt = map_big_endian(pins.lowest_addr_input,
					pins.low_addr_inputs, pins.mid_addr_inputs,
					pins.addr_input_bit17, pins.addr_input_bit18);
			end
			BUS_CARD_A, BUS_CARD_B: begin
				// mid pins are tied high here and carry no address
				addr_nxt[0] = pins.lowest_addr_input;
				addr_nxt[LOW_LSB +: LOW_W] = pins.low_addr_inputs;
				iowr_nxt = pins.addr_input_bit17;
				iord_nxt = pins.addr_input_bit18;
			end
			BUS_WORD16: begin
				lds_nxt = pins.lowest_addr_input;
				addr_nxt[LOW_LSB +: LOW_W] = pins.low_addr_inputs;
				addr_nxt[MID_LSB +: MID_W] = pins.mid_addr_inputs;
				addr_nxt[BIT17_POS] = pins.addr_input_bit17;
				addr_nxt[BIT18_POS] = pins.addr_input_bit18;
			end
			BUS_BYTE32, BUS_ISA: begin
				addr_nxt[0] = pins.lowest_addr_input;
				addr_nxt[LOW_LSB +: LOW_W] = pins.low_addr_inputs;
				addr_nxt[MID_LSB +: MID_W] = pins.mid_addr_inputs;
				addr_nxt[BIT17_POS] = pins.addr_input_bit17;
				addr_nxt[BIT18_POS] = pins.addr_input_bit18;
			end
			BUS_GENERIC, BUS_PERIPH_A, BUS_PERIPH_B, BUS_PCCARD: begin
				// lowest pin is a board tie-off, so bit 0 reads zero
				addr_nxt[LOW_LSB +: LOW_W] = pins.low_addr_inputs;
				addr_nxt[MID_LSB +: MID_W] = pins.mid_addr_inputs;
				addr_nxt[BIT17_POS] = pins.addr_input_bit17;
				addr_nxt[BIT18_POS] = pins.addr_input_bit18;
			end
		endcase
	end

	// registered address; nothing is passed before the straps are caught,
	// which costs one idle cycle after reset but hides strap glitches
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_r <= ADDR_RST;
		end else if (taken_r) begin
			addr_r <= addr_nxt;
		end
	end

	// registered strobes, idle high until the straps are caught
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lds_r  <= STROBE_IDLE;
			iowr_r <= STROBE_IDLE;
			iord_r <= STROBE_IDLE;
		end else if (taken_r) begin
			lds_r  <= lds_nxt;
			iowr_r <= iowr_nxt;
			iord_r <= iord_nxt;
		end
	end

	// strap view
	assign bus_type            = bus_type_r;
	assign map_ready           = taken_r;
	assign strap_bad           = strap_bad_r;
	assign spare_straps        = spare_r;

	// mapped view
	assign sys_addr            = addr_r;
	assign lower_byte_strobe_n = lds_r;
	assign card_io_write_n     = iowr_r;
	assign card_io_read_n      = iord_r;

endmodule

// ===== host_address_pin_mapper_properties.sv
`timescale 1ns/1ns
module host_address_pin_mapper_properties
	import addr_map_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        lowest_addr_input,
	input wire logic [11:0] low_addr_inputs,
	input wire logic [3:0]  mid_addr_inputs,
	input wire logic        addr_input_bit17,
	input wire logic        addr_input_bit18,
	input wire logic [7:0]  power_on_strap_pins,
	input wire logic [3:0]  bus_type,
	input wire logic        map_ready,
	input wire logic [18:0] sys_addr,
	input wire logic        lower_byte_strobe_n,
	input wire logic        card_io_write_n,
	input wire logic        card_io_read_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic card;
	logic tied;
	// mode groups, kept apart from the design's own helpers
	assign card = bus_type inside {BUS_CARD_A, BUS_CARD_B};
	assign tied = bus_type inside {BUS_GENERIC, BUS_PERIPH_A, BUS_PERIPH_B,
		BUS_PCCARD, BUS_WORD16};
	a_bus_from_straps: assert property (
		$rose(map_ready) |-> bus_type == ((power_on_strap_pins[3:0] > 4'h9) ?
		BUS_GENERIC : bus_type_t'(power_on_strap_pins[3:0])))
		else $error("bus type differs from straps");
	a_bus_held: assert property (
		map_ready |=> $stable(bus_type) && map_ready)
		else $error("bus type moved");
	a_bit0_addr: assert property (
		map_ready && !tied |=> sys_addr[0] == $past(lowest_addr_input))
		else $error("bit 0 not taken");
	a_bit0_ignored: assert property (
		map_ready && tied |=> sys_addr[0] == 1'b0)
		else $error("tied bit 0 used");
	a_byte_strobe: assert property (
		map_ready |=> lower_byte_strobe_n == ((bus_type == BUS_WORD16) ?
		$past(lowest_addr_input) : 1'b1))
		else $error("byte strobe wrong");
	a_low_bits: assert property (
		map_ready |=> sys_addr[12:1] == $past(low_addr_inputs))
		else $error("low bits wrong");
	a_high_bits: assert property (
		map_ready && !card |=> sys_addr[18:13] == $past({addr_input_bit18,
		addr_input_bit17, mid_addr_inputs}) && card_io_write_n && card_io_read_n)
		else $error("high bits wrong");
	a_card_strobes: assert property (
		map_ready && card |=> sys_addr[18:13] == 6'h00 &&
		card_io_write_n == $past(addr_input_bit17) &&
		card_io_read_n == $past(addr_input_bit18))
		else $error("card strobes wrong");
	a_card_tie_high: assert property (
		map_ready && card |-> mid_addr_inputs == MID_TIE_HIGH)
		else $error("card mid pins not high");
	c_card: cover property (map_ready && !card_io_read_n);
	c_word: cover property (map_ready && !lower_byte_strobe_n);
	c_big: cover property (map_ready && bus_type == BUS_BIG_ENDIAN);
endmodule

// ===== tb_host_address_pin_mapper.sv
`timescale 1ns/1ns
module tb_host_address_pin_mapper;
	import addr_map_pkg::*;
	logic        ref_clk, rst_n, host_rst_n, lbs_n, wr_n, rd_n;
	logic        map_ready, strap_bad, dev_lbs_n, dev_wr_n, dev_rd_n;
	logic [7:0]  strap_cfg;
	logic [18:0] req_addr, sys_addr;
	logic [3:0]  spare_straps;
	bus_type_t   bus_type, host_bus_type;
	int          num_errors = 0, checks = 0, cycles = 0;
	host_addr_if bus();
	host_address_driver host_address_driver_i (.ref_clk(ref_clk),
		.rst_n(host_rst_n), .pins(bus.host), .strap_cfg(strap_cfg),
		.req_addr(req_addr), .lower_byte_strobe_n(lbs_n),
		.card_io_write_n(wr_n), .card_io_read_n(rd_n),
		.host_bus_type(host_bus_type));
	host_address_pin_mapper host_address_pin_mapper_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .pins(bus.device), .bus_type(bus_type),
		.map_ready(map_ready), .strap_bad(strap_bad),
		.spare_straps(spare_straps), .sys_addr(sys_addr),
		.lower_byte_strobe_n(dev_lbs_n), .card_io_write_n(dev_wr_n),
		.card_io_read_n(dev_rd_n));
	host_address_pin_mapper_properties props_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .lowest_addr_input(bus.lowest_addr_input),
		.low_addr_inputs(bus.low_addr_inputs),
		.mid_addr_inputs(bus.mid_addr_inputs),
		.addr_input_bit17(bus.addr_input_bit17),
		.addr_input_bit18(bus.addr_input_bit18),
		.power_on_strap_pins(bus.power_on_strap_pins),
		.bus_type(bus_type), .map_ready(map_ready), .sys_addr(sys_addr),
		.lower_byte_strobe_n(dev_lbs_n), .card_io_write_n(dev_wr_n),
		.card_io_read_n(dev_rd_n));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// the whole run needs about 95 cycles; this cuts a hang short
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			num_errors++;
			complete_run();
		end
	end
	task complete_run;
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task step;
		@(posedge ref_clk);
		#10;
	endtask
	task check(input string what, input logic [21:0] exp, got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// strobes, then address, as the device should show them
	function automatic logic [21:0] expect_out(input logic [3:0] bt,
		input logic [18:0] a, input logic [2:0] s);
		logic [18:0] e;
		logic [2:0]  st;
		e = a;
		st = 3'h7;
		if (bt inside {BUS_GENERIC, BUS_PERIPH_A, BUS_PERIPH_B, BUS_PCCARD,
			BUS_WORD16})
			e[0] = 1'b0;
		if (bt == BUS_WORD16)
			st[0] = s[0];
		if (bt inside {BUS_CARD_A, BUS_CARD_B}) begin
			e[18:13] = 6'h00;
			st[2:1] = s[2:1];
		end
		expect_out = {st, e};
	endfunction
	// host then device each add one edge
	task send(input logic [18:0] a, input logic [2:0] s, input logic [3:0] bt);
		req_addr = a;
		{rd_n, wr_n, lbs_n} = s;
		step;
		step;
		check("mapping", expect_out(bt, a, s), {dev_rd_n, dev_wr_n, dev_lbs_n,
			sys_addr});
	endtask
	// the host holds the new straps before the device leaves reset
	task run_mode(input logic [7:0] strap);
		logic [3:0] bt;
		bt = (strap[3:0] > 4'h9) ? 4'h0 : strap[3:0];
		strap_cfg = strap;
		rst_n = 1'b0;
		step;
		step;
		check("map_ready", 1'b0, map_ready);
		rst_n = 1'b1;
		step;
		check("map_ready", 1'b1, map_ready);
		check("sys_addr idle", 19'h00000, sys_addr);
		check("bus_type", bt, bus_type);
		check("host_bus_type", bt, host_bus_type);
		check("strap_bad", strap[3:0] > 4'h9, strap_bad);
		check("spare_straps", strap[7:4], spare_straps);
		send(19'h5a5a5, 3'b010, bt);
		send(19'h3a5a4, 3'b101, bt);
	endtask
	task all_modes;
		for (int c = 0; c < 10; c++)
			run_mode(8'(c * 17) ^ 8'h50);
	endtask
	task bad_strap;
		run_mode(8'hac);
	endtask
	task fixed_mapping;
		run_mode(8'h09);
		strap_cfg = 8'h07;
		step;
		step;
		step;
		check("bus_type held", 4'h9, bus_type);
		send(19'h7e5a5, 3'b110, 4'h9);
	endtask
	initial begin
		rst_n = 1'b0;
		host_rst_n = 1'b0;
		strap_cfg = 8'h00;
		req_addr = 19'h00000;
		{rd_n, wr_n, lbs_n} = 3'h7;
		repeat (5) @(posedge ref_clk);
		#10;
		host_rst_n = 1'b1;
		all_modes();
		bad_strap();
		fixed_mapping();
		complete_run();
	end
endmodule
